/* File: src/sibacc_pkg.sv */
// constants for the indexed block access target
package sibacc_pkg;
	localparam logic [6:0] SIBACC_ADDR_LOW = 7'h6B;
	localparam logic [6:0] SIBACC_ADDR_MID = 7'h6C;
	localparam logic [6:0] SIBACC_ADDR_HIGH = 7'h6D;
	localparam logic [1:0] SIBACC_STRAP_LOW = 2'h0;
	localparam logic [1:0] SIBACC_STRAP_MID = 2'h1;
	localparam logic [7:0] SIBACC_IDX_OE = 8'h00;
	localparam logic [7:0] SIBACC_IDX_COUNT = 8'h07;
	localparam logic [7:0] SIBACC_OE_RESET = 8'hDD;
	localparam logic [7:0] SIBACC_OE_MASK = 8'hDD;
	localparam logic [4:0] SIBACC_COUNT_RESET = 5'h08;
	localparam logic [3:0] SIBACC_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] SIBACC_LAST_BIT = 4'h7;
	// reference considered stopped after this long without an edge
	localparam int SIBACC_REF_TIMEOUT_NS = 1000;
	localparam int SIBACC_CLK_NS = 25;
	localparam int SIBACC_REF_TIMEOUT_CYC =
		SIBACC_REF_TIMEOUT_NS / SIBACC_CLK_NS;
	typedef enum logic [5:0] {
		st_idle = 6'h01,
		st_rx = 6'h02,
		st_ack = 6'h04,
		st_tx = 6'h08,
		st_hack = 6'h10,
		st_wait = 6'h20
	} sibacc_state_type;
	typedef enum logic [1:0] {
		ph_addr = 2'h0,
		ph_index = 2'h1,
		ph_count = 2'h2,
		ph_data = 2'h3
	} sibacc_phase_type;
endpackage : sibacc_pkg

/* File: src/sibacc_target.sv */
// indexed block access target with output enable byte
`timescale 1ns/10ps
// What this block does
// - the target acknowledges address, index, count and every data byte.
// - on a read the count byte goes out first, then bytes from the index.
// - the bus address is taken from the strap once, after reset release.
// - byte 0 holds six output enables at bits 7,6,4,3,2,0, reset to one.
// - the bus interface stays idle while the reference clock is stopped.
// - a cleared enable bit forces its output off whatever the pin says.
// - the count field of byte 7 sets how many bytes follow the count byte on a read.
module sibacc_target import sibacc_pkg::*; #(
	parameter int REF_TIMEOUT = SIBACC_REF_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// strap, reference clock, pin enables
	input wire logic [1:0] address_select_strap,
	input wire logic ref_clk,
	input wire logic [5:0] out_enable_pin_n,
	// output control
	output logic [5:0] out_enable,
	output logic ref_running
);
	sibacc_state_type state_reg, state_next;
	sibacc_phase_type phase_reg, phase_next;
	logic [2:0] scl_sync_reg, sda_sync_reg, ref_sync_reg;
	logic [5:0] pin_meta_reg, pin_sync_reg;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] index_reg, index_next;
	logic [7:0] oe_byte_reg, oe_byte_next;
	logic [4:0] count_reg, count_next;
	logic [4:0] left_reg, left_next;
	logic read_reg, read_next;
	logic drive_reg, drive_next;
	logic hnak_reg, hnak_next;
	logic [6:0] dev_addr_reg, dev_addr_next;
	logic strap_done_reg, strap_done_next;
	logic [1:0] strap_meta_reg, strap_sync_reg;
	logic [1:0] strap_age_reg, strap_age_next;
	logic [31:0] ref_cnt_reg, ref_cnt_next;
	logic run_reg, run_next;
	logic [5:0] out_reg, out_next;
	logic scl_rise, scl_fall, start_det, stop_det;

	function automatic logic [7:0] read_byte(input logic [7:0] idx,
		input logic [7:0] oe, input logic [4:0] cnt);
		logic [7:0] v;
		v = 8'h00;
		if (idx == SIBACC_IDX_OE)
			v = oe;
		else if (idx == SIBACC_IDX_COUNT)
			v = {3'h0, cnt};
		return v;
	endfunction : read_byte

	function automatic logic [6:0] strap_addr(input logic [1:0] s);
		logic [6:0] a;
		a = SIBACC_ADDR_HIGH;
		if (s == SIBACC_STRAP_LOW)
			a = SIBACC_ADDR_LOW;
		else if (s == SIBACC_STRAP_MID)
			a = SIBACC_ADDR_MID;
		return a;
	endfunction : strap_addr

	assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
	assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
	assign start_det = scl_sync_reg[1] & scl_sync_reg[2] &
		~sda_sync_reg[1] & sda_sync_reg[2];
	assign stop_det = scl_sync_reg[1] & scl_sync_reg[2] &
		sda_sync_reg[1] & ~sda_sync_reg[2];
	assign sda_out = 1'b0;
	assign sda_oe = drive_reg;
	assign out_enable = out_reg;
	assign ref_running = run_reg;

	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		index_next = index_reg;
		oe_byte_next = oe_byte_reg;
		count_next = count_reg;
		left_next = left_reg;
		read_next = read_reg;
		hnak_next = hnak_reg;
		dev_addr_next = dev_addr_reg;
		// strap settles through two flops before it is taken
		strap_age_next = {strap_age_reg[0], 1'b1};
		strap_done_next = strap_done_reg | strap_age_reg[1];
		// reference activity watchdog
		ref_cnt_next = ref_cnt_reg;
		run_next = run_reg;
		if (ref_sync_reg[1] != ref_sync_reg[2]) begin
			ref_cnt_next = 32'h0;
			run_next = 1'b1;
		end else if (ref_cnt_reg >= 32'(REF_TIMEOUT)) begin
			run_next = 1'b0;
		end else begin
			ref_cnt_next = ref_cnt_reg + 32'h1;
		end
		if (strap_age_reg[1] && !strap_done_reg)
			dev_addr_next = strap_addr(strap_sync_reg);
		if (!run_reg) begin
			state_next = st_idle;
		end else if (start_det) begin
			state_next = st_rx;
			phase_next = ph_addr;
			bit_cnt_next = 4'h0;
		end else if (stop_det) begin
			state_next = st_idle;
		end else begin
			unique case (state_reg)
				st_idle, st_wait: begin
				end
				st_rx: begin
					if (scl_rise && bit_cnt_reg < SIBACC_BITS_PER_BYTE) begin
						shift_next = {shift_reg[6:0], sda_sync_reg[1]};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == SIBACC_BITS_PER_BYTE) begin
						state_next = st_ack;
						unique case (phase_reg)
							ph_addr: begin
								if (shift_reg[7:1] != dev_addr_reg)
									state_next = st_wait;
								read_next = shift_reg[0];
							end
							ph_index: index_next = shift_reg;
							ph_count: left_next = shift_reg[4:0];
							ph_data: begin
								if (index_reg == SIBACC_IDX_OE)
									oe_byte_next = shift_reg & SIBACC_OE_MASK;
								else if (index_reg == SIBACC_IDX_COUNT)
									count_next = shift_reg[4:0];
								index_next = index_reg + 8'h1;
							end
						endcase
					end
				end
				st_ack: begin
					if (scl_fall) begin
						bit_cnt_next = 4'h0;
						if (read_reg && phase_reg == ph_addr) begin
							state_next = st_tx;
							shift_next = {3'h0, count_reg};
							left_next = count_reg;
						end else begin
							state_next = st_rx;
							if (phase_reg != ph_data)
								phase_next = sibacc_phase_type'(phase_reg + 2'h1);
						end
					end
				end
				st_tx: begin
					if (scl_fall) begin
						if (bit_cnt_reg == SIBACC_LAST_BIT) begin
							state_next = st_hack;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							bit_cnt_next = bit_cnt_reg + 4'h1;
						end
					end
				end
				st_hack: begin
					if (scl_rise)
						hnak_next = sda_sync_reg[1];
					if (scl_fall) begin
						bit_cnt_next = 4'h0;
						if (hnak_reg || left_reg == 5'h0) begin
							state_next = st_wait;
						end else begin
							state_next = st_tx;
							shift_next = read_byte(index_reg, oe_byte_reg, count_reg);
							index_next = index_reg + 8'h1;
							left_next = left_reg - 5'h1;
						end
					end
				end
				default: state_next = st_idle;
			endcase
		end
		drive_next = (state_next == st_ack) ||
			(state_next == st_tx && !shift_next[7]);
		// pin enable gated by register bit
		out_next = {oe_byte_reg[7:6], oe_byte_reg[4:2], oe_byte_reg[0]} &
			~pin_sync_reg;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= st_idle;
			phase_reg <= ph_addr;
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			ref_sync_reg <= 3'h0;
			pin_meta_reg <= 6'h3F;
			pin_sync_reg <= 6'h3F;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			index_reg <= 8'h00;
			oe_byte_reg <= SIBACC_OE_RESET;
			count_reg <= SIBACC_COUNT_RESET;
			left_reg <= 5'h0;
			read_reg <= 1'b0;
			drive_reg <= 1'b0;
			hnak_reg <= 1'b1;
			dev_addr_reg <= SIBACC_ADDR_HIGH;
			strap_done_reg <= 1'b0;
			strap_meta_reg <= 2'h0;
			strap_sync_reg <= 2'h0;
			strap_age_reg <= 2'h0;
			ref_cnt_reg <= 32'h0;
			run_reg <= 1'b0;
			out_reg <= 6'h00;
		end else if (clk_en) begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			ref_sync_reg <= {ref_sync_reg[1:0], ref_clk};
			pin_meta_reg <= out_enable_pin_n;
			pin_sync_reg <= pin_meta_reg;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			index_reg <= index_next;
			oe_byte_reg <= oe_byte_next;
			count_reg <= count_next;
			left_reg <= left_next;
			read_reg <= read_next;
			drive_reg <= drive_next;
			hnak_reg <= hnak_next;
			dev_addr_reg <= dev_addr_next;
			strap_done_reg <= strap_done_next;
			strap_meta_reg <= address_select_strap;
			strap_sync_reg <= strap_meta_reg;
			strap_age_reg <= strap_age_next;
			ref_cnt_reg <= ref_cnt_next;
			run_reg <= run_next;
			out_reg <= out_next;
		end
	end
endmodule : sibacc_target

/* File: testbench/sibacc_checker.sv */
// port assertions for the indexed block access target
`timescale 1ns/10ps
module sibacc_checker #(parameter int REF_TIMEOUT = 40) (
	// clock, reset, bus pins
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe,
	// reference and output enables
	input wire logic ref_clk,
	input wire logic ref_running,
	input wire logic [5:0] out_enable_pin_n,
	input wire logic [5:0] out_enable
);
	logic [7:0] quiet_reg, quiet_next;
	logic ref_d_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// cycles since the reference last moved, saturating
	always_comb quiet_next = (ref_clk != ref_d_reg) ? 8'h00 :
		quiet_reg + {7'h00, ~&quiet_reg};
	always_ff @(posedge clk_sys or posedge reset)
		if (reset) {quiet_reg, ref_d_reg} <= 9'h000;
		else {quiet_reg, ref_d_reg} <= {quiet_next, ref_clk};
	a_stopped_no_ack: assert property (
		!ref_running [*3] |-> !sda_oe) else $error("drive while ref stopped");
	a_ref_lost: assert property (
		quiet_reg > REF_TIMEOUT + 8 |-> !ref_running) else $error("ref lost");
	a_ref_seen: assert property (
		$changed(ref_clk) |-> ##[1:8] ref_running) else $error("ref missed");
	// enables follow the pins three samples late
	a_pin_wins: assert property (
		(out_enable & $past(out_enable_pin_n, 3)) == 6'h00)
		else $error("pin disable ignored");
	a_enable_reset: assert property (
		$fell(reset) |-> ##6 out_enable == ~out_enable_pin_n)
		else $error("enable default wrong");
	a_stop_idle: assert property (
		$rose(sda_in) && scl_in |=> !sda_oe [*6]) else $error("drive after stop");
	a_scl_low: assert property (
		$changed(sda_oe) |-> !scl_in && !$past(scl_in)) else $error("sda moved");
	a_ack_stands: assert property (
		sda_oe && scl_in |=> sda_oe || !scl_in) else $error("drive dropped");
endmodule : sibacc_checker
bind sibacc_target sibacc_checker #(.REF_TIMEOUT(REF_TIMEOUT))
	sibacc_checker_inst (.clk_sys, .reset, .scl_in, .sda_in, .sda_oe,
	.ref_clk, .ref_running, .out_enable_pin_n, .out_enable);

/* File: testbench/sibacc_host.sv */
// bus host model for indexed block transfers
`timescale 1ns/10ps
module sibacc_host (
	// clock and bus lines, released level is high
	input wire logic clk_sys,
	input wire logic sda_line,
	output logic scl_drv,
	output logic sda_drv
);
	initial {scl_drv, sda_drv} = 2'h3;
	task automatic tk(input int n);
		repeat (n * 10) @(posedge clk_sys);
	endtask : tk
	// start when a is high, stop when low
	task automatic cond(input logic a);
		tk(1);
		sda_drv <= a;
		tk(1);
		scl_drv <= 1'b1;
		tk(2);
		sda_drv <= ~a;
		tk(2);
		scl_drv <= ~a;
	endtask : cond
	// nine bits, msb first, line sampled late in the high phase
	task automatic xb(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			tk(1);
			sda_drv <= tx[i];
			tk(1);
			scl_drv <= 1'b1;
			tk(2);
			rx[i] = sda_line;
			scl_drv <= 1'b0;
		end
	endtask : xb
	task automatic wr_blk(input logic [6:0] adr, input logic [7:0] idx,
		input logic [7:0] d0, d1, output logic nak);
		logic [8:0] r;
		logic [7:0] seq [5];
		seq = '{{adr, 1'b0}, idx, 8'h02, d0, d1};
		nak = 1'b0;
		cond(1'b1);
		foreach (seq[i]) begin
			xb({seq[i], 1'b1}, r);
			nak |= r[0];
		end
		cond(1'b0);
	endtask : wr_blk
	task automatic rd_blk(input logic [6:0] adr, input logic [7:0] idx,
		output logic [7:0] got [4], output logic nak);
		logic [8:0] r;
		cond(1'b1);
		xb({adr, 2'h1}, r);
		nak = r[0];
		xb({idx, 1'b1}, r);
		nak |= r[0];
		cond(1'b1);
		xb({adr, 2'h3}, r);
		nak |= r[0];
		for (int i = 0; i < 4; i++) begin
			xb({8'hFF, i == 3}, r);
			got[i] = r[8:1];
		end
		cond(1'b0);
	endtask : rd_blk
endmodule : sibacc_host

/* File: testbench/testbench.sv */
// self-checking bench for the indexed block access target
`timescale 1ns/10ps
module testbench import sibacc_pkg::*;;
	typedef struct {logic [7:0] v; logic [5:0] oe;} sibacc_row_type;
	sibacc_row_type rows [6] = '{'{8'h00, 6'h00}, '{8'hFF, 6'h3F},
		'{8'h81, 6'h21}, '{8'h24, 6'h02}, '{8'h48, 6'h14}, '{8'h10, 6'h08}};
	logic clk_sys = 1'b0, reset = 1'b1, ref_clk = 1'b0, ref_on = 1'b1;
	logic scl_drv, sda_drv, sda_out, sda_oe, ref_running, nak;
	logic [1:0] strap = 2'h0;
	logic [5:0] pin_n = 6'h00, out_enable;
	logic [7:0] got [4];
	int err_count = 0, n_compared = 0, cyc = 0;
	wire scl_in = scl_drv;
	// open drain: device drives its output level only while enabled
	wire sda_in = sda_oe ? (sda_drv & sda_out) : sda_drv;
	sibacc_target sibacc_target_inst (.clk_sys, .reset, .clk_en(1'b1),
		.scl_in, .sda_in, .sda_out, .sda_oe, .address_select_strap(strap),
		.ref_clk, .out_enable_pin_n(pin_n), .out_enable, .ref_running);
	sibacc_host sibacc_host_inst (.clk_sys, .sda_line(sda_in), .scl_drv,
		.sda_drv);
	always #12.5 clk_sys = ~clk_sys;
	initial #3 forever #100 if (ref_on) ref_clk = ~ref_clk;
	task automatic chk(input logic [7:0] g, e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic end_of_test();
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (20) @(posedge clk_sys);
		strap <= 2'h2;
		chk({2'h0, out_enable}, 8'h3F);
		sibacc_host_inst.rd_blk(SIBACC_ADDR_LOW, 8'h00, got, nak);
		chk({7'h00, nak}, 8'h00);
		chk(got[0], 8'h08);
		chk(got[1], SIBACC_OE_RESET);
		chk(got[2], 8'h00);
		$display("reset values done");
		foreach (rows[i]) begin
			sibacc_host_inst.wr_blk(SIBACC_ADDR_LOW, 8'h00, rows[i].v, 8'hA5, nak);
			repeat (10) @(posedge clk_sys);
			chk({7'h00, nak}, 8'h00);
			chk({2'h0, out_enable}, {2'h0, rows[i].oe});
			sibacc_host_inst.rd_blk(SIBACC_ADDR_LOW, 8'h00, got, nak);
			chk(got[1], rows[i].v & SIBACC_OE_MASK);
		end
		$display("enable rows done");
		pin_n <= 6'h08;
		sibacc_host_inst.wr_blk(SIBACC_ADDR_HIGH, 8'h00, 8'h00, 8'h00, nak);
		chk({7'h00, nak}, 8'h01);
		chk({2'h0, out_enable}, 8'h00);
		pin_n <= 6'h00;
		sibacc_host_inst.wr_blk(SIBACC_ADDR_LOW, 8'h06, 8'h55, 8'h02, nak);
		sibacc_host_inst.rd_blk(SIBACC_ADDR_LOW, 8'h00, got, nak);
		chk(got[0], 8'h02);
		chk(got[1], 8'h10);
		chk(got[2], 8'h00);
		chk(got[3], 8'hFF);
		chk({2'h0, out_enable}, 8'h08);
		$display("pin, address and count done");
		// mid-run reset: defaults return and the strap is taken again
		reset <= 1'b1;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk({2'h0, out_enable}, 8'h3F);
		sibacc_host_inst.rd_blk(SIBACC_ADDR_HIGH, 8'h00, got, nak);
		chk({7'h00, nak}, 8'h00);
		chk(got[0], 8'h08);
		chk(got[1], SIBACC_OE_RESET);
		$display("second reset done");
		ref_on = 1'b0;
		repeat (80) @(posedge clk_sys);
		chk({7'h00, ref_running}, 8'h00);
		sibacc_host_inst.wr_blk(SIBACC_ADDR_HIGH, 8'h00, 8'h00, 8'h00, nak);
		chk({7'h00, nak}, 8'h01);
		chk({2'h0, out_enable}, 8'h3F);
		ref_on = 1'b1;
		repeat (40) @(posedge clk_sys);
		chk({7'h00, ref_running}, 8'h01);
		sibacc_host_inst.wr_blk(SIBACC_ADDR_HIGH, 8'h00, 8'h00, 8'h00, nak);
		repeat (10) @(posedge clk_sys);
		chk({7'h00, nak}, 8'h00);
		chk({2'h0, out_enable}, 8'h00);
		$display("reference stop done");
		end_of_test();
	end
endmodule : testbench
